// *** design/pvit_panel.sv ***
// Panel end: lane decoder, window-based image placement and black fill
`timescale 1ns/1ps
`default_nettype none
module pvit_panel #(
    parameter int H_ACTIVE = pvit_pkg::PVIT_H_ACTIVE,
    parameter int V_ACTIVE = pvit_pkg::PVIT_V_ACTIVE
) (
    // System clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Link from the display source
    pvit_link_if.panel link,
    // Pixel pair stream, link clock domain
    output logic o_pix_valid,
    output logic o_pix_fill,
    output logic o_frame_first,
    output pvit_pkg::pvit_cnt_t o_pix_col,
    output pvit_pkg::pvit_cnt_t o_pix_row,
    output pvit_pkg::pvit_pix_t o_pix_left,
    output pvit_pkg::pvit_pix_t o_pix_right,
    // Frame status, system clock domain
    output logic o_frame_done,
    output pvit_pkg::pvit_cnt_t o_frame_lines,
    output logic o_alt_map
);
    import pvit_pkg::*;

    localparam pvit_cnt_t H_ACT_C = pvit_cnt_t'(H_ACTIVE);
    localparam pvit_cnt_t H_LAST_C = pvit_cnt_t'(H_ACTIVE - 1);
    localparam pvit_cnt_t V_ACT_C = pvit_cnt_t'(V_ACTIVE);
    localparam pvit_cnt_t V_LAST_C = pvit_cnt_t'(V_ACTIVE - 1);
    localparam pvit_cnt_t H_MIN_C = pvit_cnt_t'(PVIT_H_TOTAL_MIN);
    localparam pvit_cnt_t H_MAX_C = pvit_cnt_t'(PVIT_H_TOTAL_MAX);
    localparam pvit_cnt_t H_NOM_C = pvit_cnt_t'(PVIT_H_TOTAL);
    localparam logic [PVIT_LOW_W-1:0] GAP_LINES_C = PVIT_LOW_W'(PVIT_FRAME_GAP_LINES);

    // Link clock domain state
    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic map_s1;
        logic map_s2;
        logic de_d;
        logic in_frame;
        logic row_fill;
        logic tog;
        logic [PVIT_LOW_W-1:0] low_cnt;
        pvit_cnt_t hcyc;
        pvit_cnt_t line_len;
        pvit_cnt_t col;
        pvit_cnt_t row;
        pvit_cnt_t lines;
        logic vld;
        logic fill;
        logic first;
        pvit_cnt_t ocol;
        pvit_cnt_t orow;
        pvit_pix_t pl;
        pvit_pix_t pr;
    } pvit_lnk_s;

    // System clock domain state
    typedef struct packed {
        logic tog_s1;
        logic tog_s2;
        logic tog_s3;
        logic map_s1;
        logic map_s2;
        logic done;
        pvit_cnt_t lines;
    } pvit_sys_s;

    localparam pvit_lnk_s LNK_RST = '{map_s1: PVIT_ALT_RST, map_s2: PVIT_ALT_RST,
                                      line_len: H_NOM_C, default: '0};
    localparam pvit_sys_s SYS_RST = '{map_s1: PVIT_ALT_RST, map_s2: PVIT_ALT_RST,
                                      default: '0};
    localparam pvit_lnk_s LNK_HOLD = '{rst_s1: 1'h1, rst_s2: 1'h1, map_s1: PVIT_ALT_RST,
                                       map_s2: PVIT_ALT_RST, line_len: H_NOM_C, default: '0};

    pvit_lnk_s lst_ff;
    pvit_lnk_s nxt_lst;
    pvit_sys_s sys_ff;
    pvit_sys_s nxt_sys;
    pvit_word_s w0;
    pvit_word_s w1;
    logic rise;
    logic gap;
    logic [PVIT_LOW_W-1:0] gap_thr;
    logic row_ok;

    // Link lanes come from logic on the link clock itself and need no sync
    assign w0 = pvit_unpack(link.first_link_lanes, lst_ff.map_s2); // R15 R20 R14
    assign w1 = pvit_unpack(link.second_link_lanes, lst_ff.map_s2); // R19
    assign rise = w0.de & ~lst_ff.de_d; // R8
    assign gap_thr = PVIT_LOW_W'(lst_ff.line_len) * GAP_LINES_C;
    assign gap = lst_ff.low_cnt >= gap_thr; // R10
    assign row_ok = lst_ff.in_frame && (lst_ff.row < V_ACT_C);

    always_comb begin
        nxt_lst = lst_ff;
        nxt_lst.rst_s1 = i_rst;
        nxt_lst.rst_s2 = lst_ff.rst_s1;
        nxt_lst.map_s1 = link.alternate_bit_mapping;
        nxt_lst.map_s2 = lst_ff.map_s1; // R15
        nxt_lst.de_d = w0.de;
        nxt_lst.vld = 1'h0;
        nxt_lst.fill = 1'h0;
        nxt_lst.first = 1'h0;
        if (w0.de) begin
            nxt_lst.low_cnt = '0;
        end else if (lst_ff.low_cnt != '1) begin
            nxt_lst.low_cnt = lst_ff.low_cnt + 1'h1;
        end
        if (rise) begin
            nxt_lst.hcyc = pvit_cnt_t'(1);
        end else if (lst_ff.hcyc != '1) begin
            nxt_lst.hcyc = lst_ff.hcyc + 1'h1;
        end

        if (rise) begin
            nxt_lst.row_fill = 1'h0;
            nxt_lst.col = pvit_cnt_t'(1);
            if (gap) begin
                nxt_lst.in_frame = 1'h1; // R10
                nxt_lst.row = '0;
                nxt_lst.first = 1'h1;
            end else begin
                if (lst_ff.row != '1) begin
                    nxt_lst.row = lst_ff.row + 1'h1;
                end
                // A missing line or a glitch must not skew the frame detector
                if (lst_ff.hcyc >= H_MIN_C && lst_ff.hcyc <= H_MAX_C) begin
                    nxt_lst.line_len = lst_ff.hcyc;
                end
            end
            nxt_lst.vld = nxt_lst.in_frame && (nxt_lst.row < V_ACT_C);
            nxt_lst.ocol = '0; // R9
            nxt_lst.orow = nxt_lst.row;
            nxt_lst.pl = w0.pix;
            nxt_lst.pr = w1.pix;
        end else if (w0.de) begin
            // Pixels beyond the screen width are dropped
            if (lst_ff.col < H_ACT_C) begin
                nxt_lst.vld = row_ok;
                nxt_lst.ocol = pvit_cnt_t'({lst_ff.col, 1'h0}); // R19
                nxt_lst.orow = lst_ff.row;
                nxt_lst.pl = w0.pix;
                nxt_lst.pr = w1.pix;
                nxt_lst.col = lst_ff.col + 1'h1;
            end
        end else if (lst_ff.row_fill || (lst_ff.col != '0 && lst_ff.col < H_ACT_C)) begin
            nxt_lst.vld = row_ok; // R11
            nxt_lst.fill = 1'h1;
            nxt_lst.ocol = pvit_cnt_t'({lst_ff.col, 1'h0});
            nxt_lst.orow = lst_ff.row;
            nxt_lst.pl = PVIT_BLACK; // R13
            nxt_lst.pr = PVIT_BLACK;
            if (lst_ff.row_fill && lst_ff.col == H_LAST_C) begin
                nxt_lst.col = '0;
                if (lst_ff.row == V_LAST_C) begin
                    nxt_lst.row_fill = 1'h0;
                end else begin
                    nxt_lst.row = lst_ff.row + 1'h1;
                end
            end else begin
                nxt_lst.col = lst_ff.col + 1'h1;
            end
        end else if (lst_ff.in_frame && lst_ff.low_cnt == gap_thr) begin
            // Frame over: report its line count and paint the rows it lacked
            nxt_lst.tog = ~lst_ff.tog;
            nxt_lst.lines = (lst_ff.row < V_ACT_C) ? lst_ff.row + 1'h1 : V_ACT_C;
            if (lst_ff.row < V_LAST_C) begin
                nxt_lst.row_fill = 1'h1; // R11
                nxt_lst.row = lst_ff.row + 1'h1;
                nxt_lst.col = '0;
            end
        end

        if (lst_ff.rst_s2) begin
            nxt_lst = LNK_RST;
            nxt_lst.rst_s1 = i_rst;
            nxt_lst.rst_s2 = lst_ff.rst_s1;
        end
    end

    // The link clock stands still while the source is in reset, so reset is taken
    // asynchronously here and released through the two synchroniser stages
    always_ff @(posedge link.first_link_clock_pos or posedge i_rst) begin
        if (i_rst) begin
            lst_ff <= LNK_HOLD;
        end else begin
            lst_ff <= nxt_lst;
        end
    end

    // Toggle crossing; the line count is stable long before the toggle lands
    always_comb begin
        nxt_sys = sys_ff;
        nxt_sys.tog_s1 = lst_ff.tog;
        nxt_sys.tog_s2 = sys_ff.tog_s1;
        nxt_sys.tog_s3 = sys_ff.tog_s2;
        nxt_sys.map_s1 = link.alternate_bit_mapping;
        nxt_sys.map_s2 = sys_ff.map_s1;
        nxt_sys.done = sys_ff.tog_s2 ^ sys_ff.tog_s3;
        if (sys_ff.tog_s2 ^ sys_ff.tog_s3) begin
            nxt_sys.lines = lst_ff.lines;
        end
        if (i_rst) begin
            nxt_sys = SYS_RST;
        end
    end

    always_ff @(posedge i_clk) begin
        sys_ff <= nxt_sys;
    end

    assign o_pix_valid = lst_ff.vld;
    assign o_pix_fill = lst_ff.fill;
    assign o_frame_first = lst_ff.first;
    assign o_pix_col = lst_ff.ocol;
    assign o_pix_row = lst_ff.orow;
    assign o_pix_left = lst_ff.pl;
    assign o_pix_right = lst_ff.pr;
    assign o_frame_done = sys_ff.done;
    assign o_frame_lines = sys_ff.lines;
    assign o_alt_map = sys_ff.map_s2;
endmodule : pvit_panel
`default_nettype wire

// *** design/pvit_pkg.sv ***
// Shared constants, pixel and lane types, and lane mapping for the panel video link
// Functional notes
// R1: Frame 1100..1480 lines, exactly 1080 active.
// R2: Vertical blanking lasts 20..400 lines.
// R3: Line 1030..1325 clocks, 960 active.
// R4: Horizontal blanking lasts 70..365 clocks.
// R5: Pixel clock between 53 and 82 MHz; the source divides the 10 MHz system clock by 2, giving 5 MHz.
// R6: Frame rate stays within 47..63 Hz; at 5 MHz with 1100 clocks by 1125 lines the source gives about 4 Hz.
// R7: Line rate stays within 60..73 kHz; at 5 MHz and 1100 clocks per line the source gives about 4.5 kHz.
// R8: Placement only from valid-window rises.
// R9: First pixel after rise is leftmost.
// R10: Rise after eight low lines starts frame.
// R11: Missing pixels or lines shown black.
// R12: Source aligns pixel data with window.
// R13: Colours unsigned 8-bit, zero is black.
// R14: Bit 7 most significant per colour.
// R15: Select low JEIDA, otherwise alternative mapping.
// R16: First link: four data lanes, clock.
// R17: Select pin high/open alternative, ground JEIDA.
// R18: Second link carries its own clock lane.
// R19: Two adjacent pixels per clock, one per link.
// R20: Seven bits per lane per clock.
package pvit_pkg;
    localparam int PVIT_LANES = 4;
    localparam int PVIT_LANE_BITS = 7;
    localparam int PVIT_COLOR_BITS = 8;
    localparam int PVIT_CNT_W = 11;
    localparam int PVIT_LOW_W = 16;

    // Horizontal geometry in pixel clock cycles, vertical in line periods
    localparam int PVIT_H_ACTIVE = 960;
    localparam int PVIT_H_TOTAL = 1100;
    localparam int PVIT_H_TOTAL_MIN = 1030;
    localparam int PVIT_H_TOTAL_MAX = 1325;
    localparam int PVIT_H_BLANK_MIN = 70;
    localparam int PVIT_H_BLANK_MAX = 365;
    localparam int PVIT_V_ACTIVE = 1080;
    localparam int PVIT_V_TOTAL = 1125;
    localparam int PVIT_V_TOTAL_MIN = 1100;
    localparam int PVIT_V_TOTAL_MAX = 1480;
    localparam int PVIT_V_BLANK_MIN = 20;
    localparam int PVIT_V_BLANK_MAX = 400;
    localparam int PVIT_FRAME_GAP_LINES = 8;
    localparam int PVIT_LINE_PIXELS = 1920;

    // Rates of the link
    localparam real PVIT_PCLK_MIN_MHZ = 53.0;
    localparam real PVIT_PCLK_NOM_MHZ = 74.25;
    localparam real PVIT_PCLK_MAX_MHZ = 82.0;
    localparam real PVIT_FRAME_MIN_HZ = 47.0;
    localparam real PVIT_FRAME_MAX_HZ = 63.0;
    localparam real PVIT_LINE_MIN_KHZ = 60.0;
    localparam real PVIT_LINE_MAX_KHZ = 73.0;
    localparam real PVIT_SYS_CLK_MHZ = 10.0;
    localparam int PVIT_SRC_DIV = 2;
    localparam real PVIT_SRC_PCLK_MHZ = PVIT_SYS_CLK_MHZ / PVIT_SRC_DIV;

    // Mapping select reset value: high selects the alternative mapping
    localparam logic PVIT_ALT_RST = 1'h1;

    typedef logic [PVIT_CNT_W-1:0] pvit_cnt_t;
    typedef logic [3*PVIT_COLOR_BITS-1:0] pvit_pix_t;
    typedef logic [PVIT_LANES-1:0][PVIT_LANE_BITS-1:0] pvit_lanes_t;
    typedef struct packed {
        logic de;
        pvit_pix_t pix;
    } pvit_word_s;

    localparam pvit_pix_t PVIT_BLACK = 24'h000000;

    // Pixel is {red, green, blue}, each bit 7 down to bit 0
    function automatic pvit_lanes_t pvit_pack(input pvit_pix_t pix, input logic de,
                                              input logic alt);
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
        pvit_lanes_t l;
        r = pix[23:16];
        g = pix[15:8];
        b = pix[7:0];
        if (alt) begin
            l[0] = {g[0], r[5:0]};
            l[1] = {b[1:0], g[5:1]};
            l[2] = {de, 2'h0, b[5:2]};
            l[3] = {1'h0, b[7:6], g[7:6], r[7:6]};
        end else begin
            l[0] = {g[2], r[7:2]};
            l[1] = {b[3:2], g[7:3]};
            l[2] = {de, 2'h0, b[7:4]};
            l[3] = {1'h0, b[1:0], g[1:0], r[1:0]};
        end
        return l;
    endfunction : pvit_pack

    // Sync slots of lane 2 are never decoded: placement uses the window only
    function automatic pvit_word_s pvit_unpack(input pvit_lanes_t l, input logic alt);
        pvit_word_s w;
        w.de = l[2][6];
        if (alt) begin
            w.pix = {l[3][1:0], l[0][5:0], l[3][3:2], l[1][4:0], l[0][6],
                     l[3][5:4], l[2][3:0], l[1][6:5]};
        end else begin
            w.pix = {l[0][5:0], l[3][1:0], l[1][4:0], l[0][6], l[3][3:2],
                     l[2][3:0], l[1][6:5], l[3][5:4]};
        end
        return w;
    endfunction : pvit_unpack
endpackage : pvit_pkg

// *** design/pvit_link_if.sv ***
// Two-link pixel interface between display source and panel
`timescale 1ns/1ps
`default_nettype none
interface pvit_link_if;
    // Each differential pair is carried as its positive leg
    logic first_link_clock_pos;
    logic second_link_clock_pos;
    pvit_pkg::pvit_lanes_t first_link_lanes;
    pvit_pkg::pvit_lanes_t second_link_lanes;
    logic alternate_bit_mapping;

    modport source (
        output first_link_clock_pos,
        output second_link_clock_pos,
        output first_link_lanes,
        output second_link_lanes,
        output alternate_bit_mapping
    );
    modport panel (
        input first_link_clock_pos,
        input second_link_clock_pos,
        input first_link_lanes,
        input second_link_lanes,
        input alternate_bit_mapping
    );
endinterface : pvit_link_if
`default_nettype wire

// *** design/pvit_source.sv ***
// Display source end: timing generator and lane packer driving both links
`timescale 1ns/1ps
`default_nettype none
module pvit_source #(
    parameter int H_TOTAL = pvit_pkg::PVIT_H_TOTAL,
    parameter int H_ACTIVE = pvit_pkg::PVIT_H_ACTIVE,
    parameter int V_TOTAL = pvit_pkg::PVIT_V_TOTAL,
    parameter int V_ACTIVE = pvit_pkg::PVIT_V_ACTIVE
) (
    // System clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Link toward the panel
    pvit_link_if.source link,
    // Mapping choice, applied in vertical blanking
    input wire logic i_alt_map,
    // Pixel request and data
    output logic o_pix_req,
    output pvit_pkg::pvit_cnt_t o_pix_col,
    output pvit_pkg::pvit_cnt_t o_pix_row,
    input wire pvit_pkg::pvit_pix_t i_pix_left,
    input wire pvit_pkg::pvit_pix_t i_pix_right
);
    import pvit_pkg::*;

    localparam pvit_cnt_t H_TOT_C = pvit_cnt_t'(H_TOTAL - 1);
    localparam pvit_cnt_t V_TOT_C = pvit_cnt_t'(V_TOTAL - 1);
    localparam pvit_cnt_t H_ACT_C = pvit_cnt_t'(H_ACTIVE);
    localparam pvit_cnt_t V_ACT_C = pvit_cnt_t'(V_ACTIVE);
    localparam pvit_cnt_t V_LAST_C = pvit_cnt_t'(V_ACTIVE - 1);

    typedef struct packed {
        logic clk_lvl;
        logic alt;
        pvit_cnt_t hcnt;
        pvit_cnt_t vcnt;
        pvit_lanes_t lanes0;
        pvit_lanes_t lanes1;
    } pvit_src_s;

    localparam pvit_src_s SRC_RST = '{alt: PVIT_ALT_RST, default: '0};

    pvit_src_s st_ff;
    pvit_src_s nxt_st;
    logic active;

    assign active = (st_ff.hcnt < H_ACT_C) && (st_ff.vcnt < V_ACT_C); // R3 R1

    always_comb begin
        nxt_st = st_ff;
        nxt_st.clk_lvl = ~st_ff.clk_lvl; // R5
        if (st_ff.clk_lvl) begin
            // Launch on the falling link edge so the panel samples mid-cycle
            nxt_st.lanes0 = pvit_pack(active ? i_pix_left : PVIT_BLACK, active,
                                      st_ff.alt); // R12 R20
            nxt_st.lanes1 = pvit_pack(active ? i_pix_right : PVIT_BLACK, active,
                                      st_ff.alt); // R19
            if (st_ff.hcnt == H_TOT_C) begin
                nxt_st.hcnt = '0; // R3 R4
                if (st_ff.vcnt == V_TOT_C) begin
                    nxt_st.vcnt = '0; // R1 R2
                end else begin
                    nxt_st.vcnt = st_ff.vcnt + 1'h1;
                end
                // Switch mapping only in blanking so the panel's pin sync settles
                if (st_ff.vcnt == V_LAST_C) begin
                    nxt_st.alt = i_alt_map; // R17
                end
            end else begin
                nxt_st.hcnt = st_ff.hcnt + 1'h1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_ff <= SRC_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_pix_req = st_ff.clk_lvl & active;
    assign o_pix_col = st_ff.hcnt;
    assign o_pix_row = st_ff.vcnt;
    assign link.first_link_clock_pos = st_ff.clk_lvl; // R16
    assign link.second_link_clock_pos = st_ff.clk_lvl; // R18
    assign link.first_link_lanes = st_ff.lanes0;
    assign link.second_link_lanes = st_ff.lanes1;
    assign link.alternate_bit_mapping = st_ff.alt;
endmodule : pvit_source
`default_nettype wire

// *** testbench/pvit_link_monitor.sv ***
// Concurrent checks on the two-link pixel interface between source and panel
`timescale 1ns/1ps
`default_nettype none
module pvit_link_monitor #(
    parameter int H_TOTAL = 1030,
    parameter int H_ACTIVE = 16,
    parameter int V_TOTAL = 13,
    parameter int V_ACTIVE = 4
) (
    // System clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Link signals
    input wire logic first_link_clock_pos,
    input wire logic second_link_clock_pos,
    input wire pvit_pkg::pvit_lanes_t first_link_lanes,
    input wire pvit_pkg::pvit_lanes_t second_link_lanes,
    input wire logic alternate_bit_mapping
);
    import pvit_pkg::*;

    logic de_ff;
    logic seen_ff;
    logic [15:0] gap_ff;
    logic [15:0] blank_ff;
    logic [10:0] win_ff;
    logic [10:0] lines_ff;
    wire logic de = first_link_lanes[2][6];
    wire logic rise = de && !de_ff;
    wire logic long_gap = gap_ff >= 16'(2 * H_TOTAL);

    // Asynchronous clear: the link clock stands still while reset is held
    always_ff @(posedge first_link_clock_pos or posedge i_rst) begin
        if (i_rst) begin
            de_ff <= 1'h0;
            seen_ff <= 1'h0;
            gap_ff <= 16'h0;
            blank_ff <= 16'h0;
            win_ff <= 11'h0;
            lines_ff <= 11'h0;
        end else begin
            de_ff <= de;
            seen_ff <= seen_ff | rise;
            gap_ff <= rise ? 16'h1 : ((gap_ff == 16'hFFFF) ? gap_ff : gap_ff + 16'h1);
            blank_ff <= de ? 16'h0 : ((blank_ff == 16'hFFFF) ? blank_ff : blank_ff + 16'h1);
            win_ff <= de ? win_ff + 11'h1 : 11'h0;
            lines_ff <= !rise ? lines_ff : (long_gap ? 11'h1 : lines_ff + 11'h1);
        end
    end

    sequence s_clk_cycle;
        $fell(first_link_clock_pos) ##1 $rose(first_link_clock_pos);
    endsequence

    a_link_clocks_equal: assert property (@(posedge i_clk) disable iff (i_rst)
        first_link_clock_pos == second_link_clock_pos) else $error("link clocks differ");
    a_clock_divides: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(first_link_clock_pos) |=> s_clk_cycle) else $error("link clock not periodic");
    a_lanes_hold_rise: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(first_link_clock_pos) |-> $stable(first_link_lanes) && $stable(second_link_lanes))
        else $error("lanes changed at sampling edge");
    a_spare_slots_idle: assert property (@(posedge first_link_clock_pos) disable iff (i_rst)
        first_link_lanes[2][5:4] == 2'h0 && second_link_lanes[2][5:4] == 2'h0
        && first_link_lanes[3][6] == 1'h0 && second_link_lanes[3][6] == 1'h0)
        else $error("spare lane slots not idle");
    a_window_both_links: assert property (@(posedge first_link_clock_pos) disable iff (i_rst)
        de == second_link_lanes[2][6]) else $error("window differs between links");
    a_window_length: assert property (@(posedge first_link_clock_pos) disable iff (i_rst)
        de_ff && !de |-> win_ff == 11'(H_ACTIVE)) else $error("window length wrong");
    a_line_period: assert property (@(posedge first_link_clock_pos) disable iff (i_rst)
        rise && seen_ff && !long_gap |-> gap_ff == 16'(H_TOTAL)) else $error("line period wrong");
    a_hblank_length: assert property (@(posedge first_link_clock_pos) disable iff (i_rst)
        rise && seen_ff && !long_gap |-> blank_ff == 16'(H_TOTAL - H_ACTIVE))
        else $error("horizontal blanking wrong");
    a_vblank_length: assert property (@(posedge first_link_clock_pos) disable iff (i_rst)
        rise && seen_ff && long_gap |-> gap_ff == 16'((V_TOTAL - V_ACTIVE + 1) * H_TOTAL))
        else $error("vertical blanking wrong");
    a_frame_lines: assert property (@(posedge first_link_clock_pos) disable iff (i_rst)
        rise && long_gap |-> lines_ff == 11'(V_ACTIVE)) else $error("active line count wrong");
    a_map_in_blank: assert property (@(posedge first_link_clock_pos) disable iff (i_rst)
        $changed(alternate_bit_mapping) |-> !de && !de_ff) else $error("mapping changed in window");
endmodule : pvit_link_monitor
`default_nettype wire

// *** testbench/panel_video_input_timing_test.sv ***
// Bench joining display source and panel, checking wire coding and placement
`timescale 1ns/1ps
`default_nettype none
module panel_video_input_timing_test;
    import pvit_pkg::*;
    // Line kept in the accepted range; frames shrunk vertically for run time
    localparam int SH_TOT = 1030;
    localparam int SH_ACT = 16;
    localparam int SV_TOT = 13;
    localparam int SV_ACT = 4;
    localparam int PH_ACT = 20;
    localparam int PV_ACT = 5;
    localparam int LIMIT = 95000;

    logic i_clk = 1'h0;
    logic i_rst = 1'h0;
    logic i_alt_map = 1'h1;
    pvit_pix_t pix_left = PVIT_BLACK;
    pvit_pix_t pix_right = PVIT_BLACK;
    logic src_req;
    pvit_cnt_t src_col;
    pvit_cnt_t src_row;
    logic pv_valid, pv_fill, pv_first, pv_done, pv_alt;
    pvit_cnt_t pv_col, pv_row, pv_lines;
    pvit_pix_t pv_left, pv_right;
    logic fill;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;
    int frames = 0;
    int pairs = 0;

    pvit_link_if u_pvit_link_if ();
    pvit_source #(.H_TOTAL(SH_TOT), .H_ACTIVE(SH_ACT), .V_TOTAL(SV_TOT), .V_ACTIVE(SV_ACT))
    u_pvit_source (.i_clk(i_clk), .i_rst(i_rst), .link(u_pvit_link_if), .i_alt_map(i_alt_map),
        .o_pix_req(src_req), .o_pix_col(src_col), .o_pix_row(src_row),
        .i_pix_left(pix_left), .i_pix_right(pix_right));
    pvit_panel #(.H_ACTIVE(PH_ACT), .V_ACTIVE(PV_ACT))
    u_pvit_panel (.i_clk(i_clk), .i_rst(i_rst), .link(u_pvit_link_if), .o_pix_valid(pv_valid),
        .o_pix_fill(pv_fill), .o_frame_first(pv_first), .o_pix_col(pv_col), .o_pix_row(pv_row),
        .o_pix_left(pv_left), .o_pix_right(pv_right), .o_frame_done(pv_done),
        .o_frame_lines(pv_lines), .o_alt_map(pv_alt));
    pvit_link_monitor #(.H_TOTAL(SH_TOT), .H_ACTIVE(SH_ACT), .V_TOTAL(SV_TOT), .V_ACTIVE(SV_ACT))
    u_pvit_link_monitor (.i_clk(i_clk), .i_rst(i_rst),
        .first_link_clock_pos(u_pvit_link_if.first_link_clock_pos),
        .second_link_clock_pos(u_pvit_link_if.second_link_clock_pos),
        .first_link_lanes(u_pvit_link_if.first_link_lanes),
        .second_link_lanes(u_pvit_link_if.second_link_lanes),
        .alternate_bit_mapping(u_pvit_link_if.alternate_bit_mapping));

    always #50 i_clk = ~i_clk;

    // Blue is constant per link so lane coding can be judged without tracking columns
    function automatic pvit_pix_t exp_pix(input logic [7:0] pair, input pvit_cnt_t row,
                                          input logic right);
        return right ? {~pair, row[7:0], 8'h5A} : {pair, row[7:0], 8'hA5};
    endfunction : exp_pix

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    task automatic lane_check(input pvit_lanes_t l, input logic [7:0] b);
        if (u_pvit_link_if.alternate_bit_mapping) begin
            check({l[2][3:0], l[3][5:4]}, {b[5:2], b[7:6]});
        end else begin
            check({l[2][3:0], l[3][5:4]}, {b[7:4], b[1:0]});
        end
    endtask : lane_check

    task automatic results();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    task automatic wait_done();
        do @(posedge i_clk); while (pv_done !== 1'h1);
    endtask : wait_done

    always @(posedge i_clk) begin
        pix_left <= exp_pix(src_col[7:0], src_row, 1'h0);
        pix_right <= exp_pix(src_col[7:0], src_row, 1'h1);
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_mismatch++;
            results();
        end
    end

    always @(posedge u_pvit_link_if.first_link_clock_pos) begin
        if (u_pvit_link_if.first_link_lanes[2][6] === 1'h1) begin
            lane_check(u_pvit_link_if.first_link_lanes, 8'hA5);
            lane_check(u_pvit_link_if.second_link_lanes, 8'h5A);
        end
    end

    // Panel outputs stand one link cycle; look at them mid-cycle
    always @(negedge u_pvit_link_if.first_link_clock_pos) begin
        if (pv_valid === 1'h1) begin
            fill = pv_col[10:1] >= 10'(SH_ACT) || pv_row >= 11'(SV_ACT);
            if (pv_first === 1'h1) begin
                check(pv_col, 0);
                check(pv_row, 0);
                pairs = 0;
                frames++;
            end
            check(pv_fill, fill);
            check(pv_left, fill ? PVIT_BLACK : exp_pix(pv_col[8:1], pv_row, 1'h0));
            check(pv_right, fill ? PVIT_BLACK : exp_pix(pv_col[8:1], pv_row, 1'h1));
            if (pv_row < 11'(SV_ACT)) begin
                pairs++;
            end
        end
    end

    initial begin
        // Raised at time zero so the link side, whose clock stops in reset, sees an edge
        i_rst <= 1'h1;
        repeat (20) @(posedge i_clk);
        i_rst <= 1'h0;
        @(posedge i_clk);
        check(pv_alt, 1);
        check(pv_done, 0);
        wait (frames == 1);
        @(posedge i_clk);
        i_alt_map <= 1'h0;
        wait_done();
        check(frames, 1);
        check(pv_lines, SV_ACT);
        check(pairs, SV_ACT * PH_ACT);
        check(pv_alt, 0);
        check(u_pvit_link_if.alternate_bit_mapping, 0);
        wait_done();
        check(frames, 2);
        check(pv_lines, SV_ACT);
        check(pairs, SV_ACT * PH_ACT);
        results();
    end
endmodule : panel_video_input_timing_test
`default_nettype wire
